// ===== adc_cal_pkg.sv
package adc_cal_pkg;
    // =========================================
    // Register map
    localparam logic [7:0] ADR_CMD = 8'h00;
    localparam logic [7:0] ADR_CFG = 8'h04;
    localparam logic [7:0] ADR_SOFF = 8'h08;
    localparam logic [7:0] ADR_OFFA = 8'h0c;
    localparam logic [7:0] ADR_GAINA = 8'h10;
    localparam logic [7:0] ADR_OFFB = 8'h14;
    localparam logic [7:0] ADR_GAINB = 8'h18;
    localparam logic [2:0] WIN_GAIN = 3'h1;
    localparam logic [2:0] WIN_RES = 3'h2;
    // =========================================
    // Config fields
    localparam int CFG_GAIN_LSB = 0;
    localparam int CFG_LINE_FILTER_SELECT_LSB = 4;
    localparam int CFG_RATE_LSB = 8;
    localparam int CFG_SYSC_LSB = 12;
    localparam int CFG_SLOT_LSB = 16;
    localparam int CMD_SETB_BIT = 3;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [1:0] SYSC_A = 2'h1;
    localparam logic [1:0] SYSC_B = 2'h2;
    localparam logic [2:0] CMD_SELF = 3'h0;
    localparam logic [2:0] CMD_PGA = 3'h1;
    localparam logic [2:0] CMD_SYSOFF = 3'h2;
    localparam logic [2:0] CMD_SYSGAIN = 3'h3;
    // =========================================
    // Coefficient codes
    localparam logic [23:0] GAIN_UNITY = 24'h800000;
    localparam logic [23:0] GAIN_MAX = 24'hffffff;
    localparam logic [23:0] GAIN_MIN = 24'h400000;
    localparam logic [23:0] OFF_ZERO = 24'h000000;
    localparam logic [23:0] OFF_MAX = 24'h7fffff;
    localparam logic [23:0] OFF_MIN = 24'h800000;
    localparam logic [23:0] FS_TARGET = 24'h600000;
    localparam logic [51:0] FS_NUM = {3'h0, FS_TARGET, 25'h0};
    localparam logic [4:0] DIV_TOP = 5'h17;
    typedef enum logic [1:0] {
        IN_EXT = 2'b00, IN_ZERO = 2'b01, IN_FULL = 2'b10
    } conv_in_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_CONV = 3'b001, ST_EVAL = 3'b010,
        ST_DIV = 3'b011, ST_STORE = 3'b100
    } cal_state_t;
    // =========================================
    // Saturation to a 24-bit signed code
    function automatic logic [23:0] sat24(input logic signed [28:0] v);
        if (v > $signed({5'h0, OFF_MAX})) begin
            return OFF_MAX;
        end else if (v < $signed({5'h1f, OFF_MIN})) begin
            return OFF_MIN;
        end
        return v[23:0];
    endfunction
    function automatic logic [31:0] merge32(input logic [31:0] o,
        input logic [31:0] d, input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                o[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return o;
    endfunction
endpackage

// ===== coeff_mem_if.sv
`timescale 1ns/1ps
interface coeff_mem_if;
    logic we;
    logic [2:0] waddr;
    logic [23:0] wdata;
    logic [2:0] raddr_a;
    logic [23:0] rdata_a;
    logic [2:0] raddr_b;
    logic [23:0] rdata_b;
    modport ctrl(output we, waddr, wdata, raddr_a, raddr_b,
        input rdata_a, rdata_b);
    modport mem(input we, waddr, wdata, raddr_a, raddr_b,
        output rdata_a, rdata_b);
endinterface

// ===== coeff_mem.sv
`timescale 1ns/1ps
module coeff_mem
    import adc_cal_pkg::*;
#(
    parameter logic [23:0] RESET_WORD = 24'h000000
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    coeff_mem_if.mem port
);
    typedef struct packed {
        logic [7:0][23:0] w;
        logic [23:0] ra;
        logic [23:0] rb;
    } mem_t;
    mem_t r_reg, r_next;
    always_comb begin
        r_next = r_reg;
        if (port.we) begin
            r_next.w[port.waddr] = port.wdata;
        end
        r_next.ra = r_reg.w[port.raddr_a];
        r_next.rb = r_reg.w[port.raddr_b];
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            r_reg <= '{w: {8{RESET_WORD}}, ra: RESET_WORD, rb: RESET_WORD};
        end else begin
            r_reg <= r_next;
        end
    end
    assign port.rdata_a = r_reg.ra;
    assign port.rdata_b = r_reg.rb;
endmodule

// ===== result_corrector.sv
`timescale 1ns/1ps
module result_corrector
    import adc_cal_pkg::*;
(
    input wire logic [23:0] raw_i,
    input wire logic [23:0] self_off_i,
    input wire logic [23:0] self_gain_i,
    input wire logic [23:0] sys_off_i,
    input wire logic [23:0] sys_gain_i,
    output logic [27:0] inner_o,
    output logic [23:0] result_o
);
    logic signed [26:0] a;
    logic signed [51:0] p1;
    logic signed [28:0] c;
    logic signed [54:0] p2;
    always_comb begin
        // Quarter-LSB units keep offset resolution
        a = $signed({raw_i[23], raw_i, 2'b00})
            - $signed({{3{self_off_i[23]}}, self_off_i});
        p1 = a * $signed({1'b0, self_gain_i});
        inner_o = p1[50:23];
        c = $signed({inner_o[27], inner_o})
            - $signed({{5{sys_off_i[23]}}, sys_off_i});
        p2 = c * $signed({1'b0, sys_gain_i});
        result_o = sat24(p2[53:25]); // RULE5 RULE15
    end
endmodule

// ===== adc_cal_core.sv
`timescale 1ns/1ps
// Operation
// (RULE1) Reset leaves offsets at zero and gains at unity.
// (RULE2) Launch write picks self, gain-stage or system calibration and starts.
// (RULE3) Host may write coefficients directly; written values are used.
// (RULE4) One internal gain coefficient per amplifier gain, selected one applied.
// (RULE5) Result is system gain times (inner corrected minus system offset).
// (RULE6) Corrected result goes to one of eight slots by select field.
// (RULE7) Calibration runs at programmed filter, rate and gain.
// (RULE8) System set A, B or none applies by select field.
// (RULE9) Self calibration uses internal zero and full scale at set gain.
// (RULE10) Gain correction spans half to double; offset spans quarter reference.
// (RULE11) Gain codes unsigned 24-bit, unity at midcode.
// (RULE12) Offset codes 24-bit two's complement, clamped to extremes.
// (RULE13) Code 000: two conversions, update offset and unity gain coefficient.
// (RULE14) Code 001: one conversion, update gain of selected setting.
// (RULE15) Correction saturates instead of wrapping.
module adc_cal_core
    import adc_cal_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [23:0] conv_data_i,
    input wire logic conv_valid_i,
    output logic conv_start_o,
    output logic [1:0] conv_input_o,
    output logic [2:0] conv_gain_o,
    output logic [1:0] conv_filter_o,
    output logic [3:0] conv_rate_o,
    output logic cal_busy_o,
    output logic result_valid_o,
    output logic [23:0] result_data_o
);
    // =========================================
    // State
    typedef struct packed {
        logic ack;
        logic phase;
        logic [31:0] rdat;
        cal_state_t st;
        logic [2:0] cmd;
        logic setb;
        logic second;
        logic [23:0] self_off;
        logic [1:0][23:0] sys_off;
        logic [1:0][23:0] sys_gain;
        logic [2:0] gain;
        logic [1:0] line_filter_select;
        logic [3:0] rate;
        logic [1:0] sysc;
        logic [3:0] slot;
        logic start;
        conv_in_t conv_in;
        logic [23:0] raw;
        logic raw_v;
        logic [27:0] den;
        logic [23:0] quo;
        logic [4:0] bitn;
        logic out_v;
        logic [23:0] out_d;
        logic busy;
    } ctl_t;
    ctl_t r_reg, r_next;
    coeff_mem_if gm ();
    coeff_mem_if rm ();
    logic [23:0] c_sys_off;
    logic [23:0] c_sys_gain;
    logic [27:0] c_inner;
    logic [23:0] c_result;
    logic req;
    logic wr;
    logic [31:0] rd;
    logic [31:0] merged;
    logic [23:0] trial;
    logic [51:0] prod;
    // =========================================
    // Submodules
    coeff_mem #(.RESET_WORD(GAIN_UNITY)) u_gain_mem ( // RULE1 RULE4
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .port(gm.mem)
    );
    coeff_mem #(.RESET_WORD(OFF_ZERO)) u_result_mem (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .port(rm.mem)
    );
    result_corrector u_corr (
        .raw_i(r_reg.raw),
        .self_off_i(r_reg.self_off),
        .self_gain_i(gm.rdata_b),
        .sys_off_i(c_sys_off),
        .sys_gain_i(c_sys_gain),
        .inner_o(c_inner),
        .result_o(c_result)
    );
    // =========================================
    // Next state
    always_comb begin
        r_next = r_reg;
        r_next.start = 1'b0;
        r_next.raw_v = 1'b0;
        r_next.out_v = 1'b0;
        r_next.ack = 1'b0;
        req = wb_cyc_i && wb_stb_i;
        wr = req && wb_we_i && r_reg.phase;
        rd = 32'h0000_0000;
        trial = r_reg.quo | (24'h000001 << r_reg.bitn);
        prod = {28'h0, trial} * {24'h0, r_reg.den};
        // System set selection
        c_sys_off = OFF_ZERO; // RULE8
        c_sys_gain = GAIN_UNITY;
        if (r_reg.sysc == SYSC_A) begin
            c_sys_off = r_reg.sys_off[0];
            c_sys_gain = r_reg.sys_gain[0];
        end else if (r_reg.sysc == SYSC_B) begin
            c_sys_off = r_reg.sys_off[1];
            c_sys_gain = r_reg.sys_gain[1];
        end
        gm.raddr_a = wb_adr_i[4:2];
        gm.raddr_b = r_reg.gain; // RULE4
        gm.we = 1'b0;
        gm.waddr = wb_adr_i[4:2];
        rm.raddr_a = wb_adr_i[4:2];
        rm.raddr_b = r_reg.slot[2:0];
        rm.we = r_reg.raw_v; // RULE6
        rm.waddr = r_reg.slot[2:0];
        rm.wdata = c_result;
        // Bus handshake
        if (req && !r_reg.ack && !r_reg.phase) begin
            r_next.phase = 1'b1;
        end
        if (r_reg.phase) begin
            r_next.phase = 1'b0;
            r_next.ack = 1'b1;
        end
        // Read mux
        if (wb_adr_i[7:5] == WIN_GAIN) begin
            rd = {8'h0, gm.rdata_a};
        end else if (wb_adr_i[7:5] == WIN_RES) begin
            rd = {8'h0, rm.rdata_a};
        end else begin
            case (wb_adr_i)
                ADR_CMD: rd = {24'h0, (r_reg.st != ST_IDLE),
                    r_reg.second, 1'b0, r_reg.st != ST_IDLE,
                    r_reg.setb, r_reg.cmd};
                ADR_CFG: begin
                    rd[CFG_GAIN_LSB +: 3] = r_reg.gain;
                    rd[CFG_LINE_FILTER_SELECT_LSB +: 2] = r_reg.line_filter_select;
                    rd[CFG_RATE_LSB +: 4] = r_reg.rate;
                    rd[CFG_SYSC_LSB +: 2] = r_reg.sysc;
                    rd[CFG_SLOT_LSB +: 4] = r_reg.slot;
                end
                ADR_SOFF: rd = {8'h0, r_reg.self_off};
                ADR_OFFA: rd = {8'h0, r_reg.sys_off[0]};
                ADR_GAINA: rd = {8'h0, r_reg.sys_gain[0]};
                ADR_OFFB: rd = {8'h0, r_reg.sys_off[1]};
                ADR_GAINB: rd = {8'h0, r_reg.sys_gain[1]};
                default: rd = 32'h0000_0000;
            endcase
        end
        // Byte-lane merge over the current register or memory word
        merged = merge32(rd, wb_dat_i, wb_sel_i);
        gm.wdata = merged[23:0];
        if (r_reg.phase) begin
            r_next.rdat = wb_we_i ? 32'h0000_0000 : rd;
        end
        // Direct coefficient and config writes
        if (wr) begin
            if (wb_adr_i[7:5] == WIN_GAIN) begin
                gm.we = 1'b1; // RULE3
            end
            case (wb_adr_i)
                ADR_CFG: begin
                    rd = merge32(rd, wb_dat_i, wb_sel_i);
                    r_next.gain = rd[CFG_GAIN_LSB +: 3];
                    r_next.line_filter_select = rd[CFG_LINE_FILTER_SELECT_LSB +: 2];
                    r_next.rate = rd[CFG_RATE_LSB +: 4];
                    r_next.sysc = rd[CFG_SYSC_LSB +: 2];
                    r_next.slot = rd[CFG_SLOT_LSB +: 4];
                end
                ADR_SOFF: r_next.self_off =
                    merged[23:0]; // RULE3
                ADR_OFFA: r_next.sys_off[0] =
                    merged[23:0];
                ADR_GAINA: r_next.sys_gain[0] =
                    merged[23:0];
                ADR_OFFB: r_next.sys_off[1] =
                    merged[23:0];
                ADR_GAINB: r_next.sys_gain[1] =
                    merged[23:0];
                default: ;
            endcase
        end
        // Calibration sequencer
        case (r_reg.st)
            ST_IDLE: begin
                if (conv_valid_i) begin
                    r_next.raw = conv_data_i;
                    r_next.raw_v = 1'b1;
                end
                if (wr && wb_adr_i == ADR_CMD && wb_sel_i[0]
                    && wb_dat_i[2] == 1'b0) begin
                    r_next.cmd = wb_dat_i[2:0]; // RULE2
                    r_next.setb = wb_dat_i[CMD_SETB_BIT];
                    r_next.second = 1'b0;
                    r_next.st = ST_CONV;
                    r_next.start = 1'b1;
                    r_next.raw_v = 1'b0;
                    case (wb_dat_i[1:0])
                        2'b00: r_next.conv_in = IN_ZERO; // RULE9 RULE13
                        2'b01: r_next.conv_in = IN_FULL; // RULE14
                        default: r_next.conv_in = IN_EXT;
                    endcase
                end
            end
            ST_CONV: begin
                if (conv_valid_i) begin
                    r_next.raw = conv_data_i;
                    r_next.st = ST_EVAL;
                end
            end
            ST_EVAL: begin
                r_next.bitn = DIV_TOP;
                r_next.quo = OFF_ZERO;
                r_next.st = ST_DIV;
                r_next.den = {{2{r_reg.raw[23]}}, r_reg.raw, 2'b00}
                    - {{4{r_reg.self_off[23]}}, r_reg.self_off};
                if (r_reg.cmd == CMD_SELF && !r_reg.second) begin
                    r_next.self_off = sat24({{3{r_reg.raw[23]}},
                        r_reg.raw, 2'b00}); // RULE10 RULE12 RULE13
                    r_next.second = 1'b1;
                    r_next.st = ST_CONV;
                    r_next.start = 1'b1;
                    r_next.conv_in = IN_FULL; // RULE9
                end else if (r_reg.cmd == CMD_SYSOFF) begin
                    r_next.sys_off[r_reg.setb] =
                        sat24({c_inner[27], c_inner}); // RULE12
                    r_next.st = ST_IDLE;
                end else if (r_reg.cmd == CMD_SYSGAIN) begin
                    r_next.den = c_inner - {{4{r_reg.sys_off[r_reg.setb][23]}},
                        r_reg.sys_off[r_reg.setb]};
                end
            end
            ST_DIV: begin
                if (r_reg.den[27] || r_reg.den == 28'h0) begin
                    r_next.quo = GAIN_MAX; // RULE11
                    r_next.st = ST_STORE;
                end else begin
                    if (prod <= FS_NUM) begin
                        r_next.quo = trial;
                    end
                    if (r_reg.bitn == 5'h0) begin
                        r_next.st = ST_STORE;
                    end else begin
                        r_next.bitn = r_reg.bitn - 5'h1;
                    end
                end
            end
            ST_STORE: begin
                r_next.st = ST_IDLE;
                if (r_reg.quo < GAIN_MIN) begin
                    r_next.quo = GAIN_MIN; // RULE10
                end
                if (r_reg.cmd == CMD_SYSGAIN) begin
                    r_next.sys_gain[r_reg.setb] = r_next.quo;
                end else begin
                    gm.we = 1'b1;
                    gm.wdata = r_next.quo;
                    gm.waddr = (r_reg.cmd == CMD_PGA) ? r_reg.gain
                        : 3'h0; // RULE13 RULE14
                end
            end
            default: r_next.st = ST_IDLE;
        endcase
        r_next.busy = (r_next.st != ST_IDLE);
        if (r_reg.raw_v) begin
            r_next.out_v = 1'b1;
            r_next.out_d = c_result;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            r_reg <= '0;
            r_reg.gain <= CFG_RESET[CFG_GAIN_LSB +: 3];
            r_reg.self_off <= OFF_ZERO; // RULE1
            r_reg.sys_off <= {2{OFF_ZERO}};
            r_reg.sys_gain <= {2{GAIN_UNITY}};
            r_reg.st <= ST_IDLE;
            r_reg.conv_in <= IN_EXT;
        end else begin
            r_reg <= r_next;
        end
    end
    // =========================================
    // Outputs
    assign wb_dat_o = r_reg.rdat;
    assign wb_ack_o = r_reg.ack;
    assign conv_start_o = r_reg.start;
    assign conv_input_o = r_reg.conv_in;
    assign conv_gain_o = r_reg.gain; // RULE7
    assign conv_filter_o = r_reg.line_filter_select;
    assign conv_rate_o = r_reg.rate;
    assign cal_busy_o = r_reg.busy;
    assign result_valid_o = r_reg.out_v;
    assign result_data_o = r_reg.out_d;
    // =========================================
    // Checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_self_launch;
        r_reg.st == ST_EVAL && r_reg.cmd == CMD_SELF && !r_reg.second;
    endsequence
    sequence s_full_conv;
        r_reg.st == ST_CONV && r_reg.start && r_reg.conv_in == IN_FULL;
    endsequence
    a_reset_coeff_zero: assert property ($past(rst_i) |-> // RULE1
        r_reg.self_off == OFF_ZERO && r_reg.sys_gain[1] == GAIN_UNITY)
        else $error("coefficients not at reset values");
    a_launch_starts: assert property (r_reg.st == ST_IDLE && wr // RULE2
        && wb_adr_i == ADR_CMD && wb_sel_i[0] && !wb_dat_i[2]
        |=> r_reg.start && r_reg.st == ST_CONV)
        else $error("launch did not start calibration");
    a_direct_write: assert property (wr && wb_adr_i == ADR_OFFA // RULE3
        && wb_sel_i == 4'hf && r_reg.st == ST_IDLE
        |=> r_reg.sys_off[0] == $past(wb_dat_i[23:0]))
        else $error("direct coefficient write lost");
    a_self_second_conv: assert property (s_self_launch |=> // RULE13
        s_full_conv) else $error("self calibration second step wrong");
    a_self_zero_input: assert property (r_reg.start && r_reg.cmd == // RULE9
        CMD_SELF && !r_reg.second |-> r_reg.conv_in == IN_ZERO)
        else $error("self calibration not on internal zero");
    a_gain_store_slot: assert property (r_reg.st == ST_STORE // RULE14
        && r_reg.cmd == CMD_PGA |-> gm.we && gm.waddr == r_reg.gain)
        else $error("gain stage stored to wrong slot");
    a_gain_range: assert property (r_reg.st == ST_STORE && gm.we // RULE10
        |-> gm.wdata >= GAIN_MIN) else $error("gain below half");
    a_result_slot: assert property (conv_valid_i && r_reg.st == // RULE6
        ST_IDLE && !wr |=> rm.we && rm.waddr == r_reg.slot[2:0]
        ##1 result_valid_o) else $error("result not written to slot");
    a_no_system_set: assert property (r_reg.sysc == 2'h0 // RULE8
        |-> c_sys_gain == GAIN_UNITY && c_sys_off == OFF_ZERO)
        else $error("system set applied when none chosen");
    a_cal_settings: assert property (cal_busy_o && $stable(r_reg.rate) // RULE7
        |-> conv_rate_o == r_reg.rate && conv_gain_o == r_reg.gain)
        else $error("calibration settings not presented");
endmodule

// ===== conv_src_model.sv
`timescale 1ns/1ps
module conv_src_model
    import adc_cal_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic start_i,
    input wire logic [1:0] input_sel_i,
    output logic valid_o,
    output logic [23:0] data_o
);
    int lat = 1;
    logic [23:0] val;
    initial begin
        valid_o = 1'b0;
        data_o = 24'h5a5a5a;
    end
    // =========================================
    // Answer calibration requests, slow and prompt in turn
    initial forever begin
        @(negedge core_clk_i);
        if (start_i) begin
            val = (input_sel_i == IN_ZERO) ? 24'h000010 : 24'h400010;
            lat = (lat == 1) ? 9 : 1;
            repeat (lat) @(posedge core_clk_i);
            send(val);
        end
    end
    task automatic send(input logic [23:0] d);
        valid_o <= 1'b1;
        data_o <= d;
        @(posedge core_clk_i);
        valid_o <= 1'b0;
        data_o <= ~d;
    endtask
endmodule

// ===== adc_calibration_correction_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin checks_done++; if ((ex) !== (sn)) begin \
    err_total++; $display("unexpected %s exp %h got %h", nm, ex, sn); end end
module adc_calibration_correction_tb
    import adc_cal_pkg::*;
;
    logic clk, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, conv_valid_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic wb_ack_o, conv_start_o, cal_busy_o, result_valid_o;
    logic [23:0] conv_data_i, result_data_o;
    logic [1:0] conv_input_o, conv_filter_o;
    logic [2:0] conv_gain_o;
    logic [3:0] conv_rate_o;
    int err_total = 0, checks_done = 0, cyc_n = 0, seed = 32'hace82d09;
    longint soff = 0, oa = 0, ga = 64'h800000, ob = 0, gb = 64'h800000;
    longint ig[8] = '{8{64'h800000}};
    int ssel = 0, gsel = 0, slot = 0;
    logic [10:0] starts[$];
    adc_cal_core dut_u (.core_clk_i(clk), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .conv_data_i(conv_data_i), .conv_valid_i(conv_valid_i),
        .conv_start_o(conv_start_o), .conv_input_o(conv_input_o),
        .conv_gain_o(conv_gain_o), .conv_filter_o(conv_filter_o),
        .conv_rate_o(conv_rate_o), .cal_busy_o(cal_busy_o),
        .result_valid_o(result_valid_o), .result_data_o(result_data_o));
    conv_src_model mod_u (.core_clk_i(clk), .start_i(conv_start_o),
        .input_sel_i(conv_input_o), .valid_o(conv_valid_i),
        .data_o(conv_data_i));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // =========================================
    // Verdict and hang guard
    task automatic summarize();
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (conv_start_o === 1'b1) begin
            starts.push_back({conv_input_o, conv_gain_o, conv_filter_o,
                conv_rate_o});
        end
        cyc_n++;
        if (cyc_n == 20000) begin
            err_total++;
            summarize();
        end
    end
    // =========================================
    // Bus cycle and reference model
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) err_total++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic cfg(input int g, input int ss, input int sl);
        gsel = g;
        ssel = ss;
        slot = sl;
        wb(1, ADR_CFG, {12'h0, 4'(sl), 2'h0, 2'(ss), 4'h5, 2'h0, 2'h1,
            1'b0, 3'(g)}, rd);
    endtask
    function automatic logic [23:0] corr(input logic [23:0] r);
        longint v, so, sg;
        so = 0;
        sg = 64'h800000;
        if (ssel == 1) begin
            so = oa;
            sg = ga;
        end
        if (ssel == 2) begin
            so = ob;
            sg = gb;
        end
        v = ((longint'($signed(r)) - soff / 4) * ig[gsel]) >>> 23;
        v = ((v - so / 4) * sg) >>> 23;
        if (v > 64'sh7fffff) v = 64'sh7fffff;
        if (v < -64'sh800000) v = -64'sh800000;
        return v[23:0];
    endfunction
    task automatic conv(input logic [23:0] r);
        logic [23:0] e;
        int n;
        e = corr(r);
        @(posedge clk);
        mod_u.send(r);
        n = 0;
        while (result_valid_o !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        `CHK("valid", 1'b1, result_valid_o);
        `CHK("result", e, result_data_o);
        wb(0, 8'h40 + 8'(4 * (slot % 8)), 0, rd);
        `CHK("slot", e, rd[23:0]);
    endtask
    task automatic cal_step(input conv_in_t src, input logic [2:0] g);
        int n;
        logic [10:0] s;
        n = 0;
        while (starts.size() == 0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        s = (starts.size() > 0) ? starts.pop_front() : 11'h7ff;
        `CHK("input", src, s[10:9]);
        `CHK("cal cfg", {g, 2'h1, 4'h5}, s[8:0]);
    endtask
    task automatic cal_wait();
        int n;
        n = 0;
        while (cal_busy_o !== 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        `CHK("busy", 1'b0, cal_busy_o);
    endtask
    // =========================================
    // Main sequence
    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hf;
        repeat (12) @(posedge clk);
        rst_i <= 1'b0;
        for (int i = 2; i < 16; i++) begin
            wb(0, 8'(4 * i), 0, rd);
            `CHK("reset", (i < 4 || i == 5 || i == 7) ? 32'h0 :
                32'h800000, rd);
        end
        for (int s = 0; s < 8; s++) begin
            cfg(0, 0, s + ((s % 2) * 8));
            conv(24'($random(seed)));
        end
        wb(1, 8'h2c, 32'h400000, rd);
        ig[3] = 64'h400000;
        for (int g = 3; g >= 0; g -= 3) begin
            cfg(g, 0, 1);
            conv(24'($random(seed)) & 24'hfffffe);
        end
        wb(1, ADR_OFFA, 32'h400, rd);
        wb(1, ADR_OFFB, 32'hfffe00, rd);
        wb(1, ADR_GAINB, 32'h400000, rd);
        oa = 64'h400;
        ob = -64'sh200;
        gb = 64'h400000;
        for (int ss = 1; ss < 4; ss++) begin
            cfg(0, ss, 2);
            conv(24'($random(seed)) & 24'hfffffe);
        end
        wb(1, ADR_OFFB, 32'h0, rd);
        wb(1, ADR_GAINB, 32'hffffff, rd);
        ob = 0;
        gb = 64'hffffff;
        cfg(0, 2, 4);
        conv(24'h7ffffe);
        conv(24'h800002);
        wb(1, ADR_CMD, 32'h4, rd);
        repeat (3) @(negedge clk);
        `CHK("refused", 1'b0, cal_busy_o);
        cfg(0, 0, 5);
        wb(1, ADR_CMD, {29'h0, CMD_SELF}, rd);
        cal_step(IN_ZERO, 3'h0);
        cal_step(IN_FULL, 3'h0);
        cal_wait();
        wb(0, ADR_SOFF, 0, rd);
        `CHK("self offset", 24'h40, rd[23:0]);
        wb(0, 8'h20, 0, rd);
        `CHK("self gain", 24'hc00000, rd[23:0]);
        soff = 64'h40;
        ig[0] = 64'hc00000;
        conv(24'h100010);
        cfg(2, 0, 6);
        wb(1, ADR_CMD, {29'h0, CMD_PGA}, rd);
        cal_step(IN_FULL, 3'h2);
        cal_wait();
        wb(0, 8'h28, 0, rd);
        `CHK("stage gain", 24'hc00000, rd[23:0]);
        summarize();
    end
endmodule
